// ---- pkg/bsmr_defines.vh ----
// Contract
// - block one from 0x7CFF, 0x7C registers
// - block two from 0x7D7B, 0x76 registers
// - block three from 0x7E53, 0x60 registers
// - byte count equals twice register count
// - registers sent high byte first, ascending
// - quality bits mark each status bit valid
// - status bit 0 shows open or closed
// - bit 1 trip, zero with motor operator
// - bit 2 set only on electrical fault trip
// - bit 3 spring charged, zero with motor
// - protocol address is register number minus one
// - bit 15 set makes other bits insignificant
`ifndef BSMR_DEFINES_VH
`define BSMR_DEFINES_VH
// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define BSMR_ADDR_QUALITY 16'h7CFF
`define BSMR_ADDR_STATUS 16'h7D00
`define BSMR_REG_BASE_NUM 16'h7D00
// ---------------------------------------------------------------
// block reads of the standard dataset
// ---------------------------------------------------------------
`define BSMR_BLK1_ADDR 16'h7CFF
`define BSMR_BLK1_CNT 16'h007C
`define BSMR_BLK2_ADDR 16'h7D7B
`define BSMR_BLK2_CNT 16'h0076
`define BSMR_BLK3_ADDR 16'h7E53
`define BSMR_BLK3_CNT 16'h0060
`define BSMR_MAX_CNT 16'h007D
// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define BSMR_BIT_OPEN_CLOSED 0
`define BSMR_BIT_TRIP 1
`define BSMR_BIT_FAULT_TRIP 2
`define BSMR_BIT_SPRING 3
`define BSMR_BIT_UNAVAIL 15
`define BSMR_STATUS_MASK 16'h800F
`define BSMR_RESET_WORD 16'h0000
`define BSMR_RESET_BYTE 8'h00
`endif

// ---- rtl/bsmr_word_src.v ----
`timescale 1ns/100ps
`default_nettype none
`include "bsmr_defines.vh"
module bsmr_word_src (
    input wire i_clk,
    input wire i_rstn,
    input wire i_open_closed_contact,
    input wire i_trip_contact,
    input wire i_fault_trip_contact,
    input wire i_spring_charged_contact,
    input wire i_motor_operator,
    input wire i_data_unavail,
    input wire [3:0] i_contact_valid,
    output reg [15:0] o_status,
    output reg [15:0] o_quality
);
    // build status and quality words each cycle
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_status <= `BSMR_RESET_WORD;
            o_quality <= `BSMR_RESET_WORD;
        end else begin
            o_status <= `BSMR_RESET_WORD;
            o_status[`BSMR_BIT_OPEN_CLOSED] <= i_open_closed_contact;
            o_status[`BSMR_BIT_TRIP] <= i_trip_contact & ~i_motor_operator;
            o_status[`BSMR_BIT_FAULT_TRIP] <= i_fault_trip_contact;
            o_status[`BSMR_BIT_SPRING] <= i_spring_charged_contact & ~i_motor_operator;
            o_status[`BSMR_BIT_UNAVAIL] <= i_data_unavail;
            o_quality <= {~i_data_unavail, 11'h000, i_contact_valid};
        end
    end
endmodule
`default_nettype wire

// ---- rtl/bsmr_readout.v ----
`timescale 1ns/100ps
`default_nettype none
`include "bsmr_defines.vh"
module bsmr_readout (
    input wire i_clk,
    input wire i_rstn,
    input wire i_open_closed_contact,
    input wire i_trip_contact,
    input wire i_fault_trip_contact,
    input wire i_spring_charged_contact,
    input wire i_motor_operator,
    input wire i_data_unavail,
    input wire [3:0] i_contact_valid,
    input wire i_req_valid,
    input wire [15:0] i_req_addr,
    input wire [15:0] i_req_count,
    input wire i_byte_ready,
    output reg o_busy,
    output reg o_byte_valid,
    output reg [7:0] o_byte,
    output reg o_byte_last,
    output reg o_req_error
);
    // ---------------------------------------------------------------
    // state codes
    // ---------------------------------------------------------------
    localparam S_IDLE = 2'd0;
    localparam S_COUNT = 2'd1;
    localparam S_HI = 2'd2;
    localparam S_LO = 2'd3;

    wire [15:0] status_w;
    wire [15:0] quality_w;
    reg [1:0] state_q, state_d;
    reg [15:0] addr_q, addr_d;
    reg [15:0] left_q, left_d;
    reg [15:0] word_q, word_d;
    reg byte_valid_d, byte_last_d, busy_d, err_d;
    reg [7:0] byte_d;

    // ---------------------------------------------------------------
    // register word lookup
    // ---------------------------------------------------------------
    // maps protocol address to value, unmapped read as zero
    function [15:0] reg_value;
        input [15:0] addr;
        input [15:0] st;
        input [15:0] ql;
        begin
            if (addr == `BSMR_ADDR_QUALITY) begin
                reg_value = ql;
            end else if (addr == `BSMR_ADDR_STATUS) begin
                reg_value = st & `BSMR_STATUS_MASK;
            end else begin
                reg_value = `BSMR_RESET_WORD;
            end
        end
    endfunction

    bsmr_word_src u_src (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_open_closed_contact(i_open_closed_contact),
        .i_trip_contact(i_trip_contact),
        .i_fault_trip_contact(i_fault_trip_contact),
        .i_spring_charged_contact(i_spring_charged_contact),
        .i_motor_operator(i_motor_operator),
        .i_data_unavail(i_data_unavail),
        .i_contact_valid(i_contact_valid),
        .o_status(status_w),
        .o_quality(quality_w)
    );

    // ---------------------------------------------------------------
    // response sequencer
    // ---------------------------------------------------------------
    // byte count, then each register high then low, ascending
    always @* begin
        state_d = state_q;
        addr_d = addr_q;
        left_d = left_q;
        word_d = word_q;
        byte_valid_d = o_byte_valid;
        byte_d = o_byte;
        byte_last_d = o_byte_last;
        busy_d = o_busy;
        err_d = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (i_req_valid) begin
                    // request address is register number minus one
                    if (i_req_count == 16'h0000 || i_req_count > `BSMR_MAX_CNT) begin
                        err_d = 1'b1;
                    end else begin
                        addr_d = i_req_addr;
                        left_d = i_req_count;
                        busy_d = 1'b1;
                        byte_valid_d = 1'b1;
                        byte_d = {i_req_count[6:0], 1'b0};
                        byte_last_d = 1'b0;
                        state_d = S_COUNT;
                    end
                end
            end
            S_COUNT: begin
                if (i_byte_ready) begin
                    word_d = reg_value(addr_q, status_w, quality_w);
                    byte_d = word_d[15:8];
                    state_d = S_HI;
                end
            end
            S_HI: begin
                if (i_byte_ready) begin
                    byte_d = word_q[7:0];
                    byte_last_d = (left_q == 16'h0001);
                    state_d = S_LO;
                end
            end
            S_LO: begin
                if (i_byte_ready) begin
                    if (left_q == 16'h0001) begin
                        byte_valid_d = 1'b0;
                        byte_last_d = 1'b0;
                        busy_d = 1'b0;
                        state_d = S_IDLE;
                    end else begin
                        left_d = left_q - 16'h0001;
                        addr_d = addr_q + 16'h0001;
                        word_d = reg_value(addr_d, status_w, quality_w);
                        byte_d = word_d[15:8];
                        state_d = S_HI;
                    end
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // state and output registers
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            state_q <= S_IDLE;
            addr_q <= `BSMR_RESET_WORD;
            left_q <= `BSMR_RESET_WORD;
            word_q <= `BSMR_RESET_WORD;
            o_busy <= 1'b0;
            o_byte_valid <= 1'b0;
            o_byte <= `BSMR_RESET_BYTE;
            o_byte_last <= 1'b0;
            o_req_error <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            left_q <= left_d;
            word_q <= word_d;
            o_busy <= busy_d;
            o_byte_valid <= byte_valid_d;
            o_byte <= byte_d;
            o_byte_last <= byte_last_d;
            o_req_error <= err_d;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/bsmr_readout_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module bsmr_readout_props (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req_valid,
    input wire logic [15:0] i_req_count,
    input wire logic i_byte_ready,
    input wire logic o_busy,
    input wire logic o_byte_valid,
    input wire logic [7:0] o_byte,
    input wire logic o_byte_last,
    input wire logic o_req_error
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ----------------------------------------
    // response framing
    // ----------------------------------------
    wire logic take = i_req_valid && !o_busy;
    wire logic bad = i_req_count == 16'h0000 || i_req_count > 16'h007D;
    AST_BYTE_COUNT: assert property (take && !bad |=> o_byte_valid &&
        o_byte == {$past(i_req_count[6:0]), 1'b0}) else $error("bad byte count");
    AST_REFUSE: assert property (take && bad |=> o_req_error && !o_busy)
        else $error("bad count not refused");
    AST_ERR_CAUSE: assert property (o_req_error |-> $past(i_req_valid))
        else $error("error without request");
    AST_HOLD: assert property (o_byte_valid && !i_byte_ready |=>
        o_byte_valid && $stable(o_byte) && $stable(o_byte_last)) else $error("byte dropped");
    AST_END: assert property (o_byte_last && i_byte_ready |=> !o_byte_valid && !o_busy)
        else $error("no end after last");
    AST_LAST: assert property (o_byte_last |-> o_byte_valid && o_busy)
        else $error("stray last");
    AST_IDLE: assert property (!o_busy |-> !o_byte_valid)
        else $error("byte while idle");
    AST_START: assert property ($rose(o_busy) |-> o_byte_valid && $past(i_req_valid))
        else $error("busy without request");
    cover property (o_req_error);
    cover property (o_busy && i_req_valid);
    cover property (o_byte_valid && !i_byte_ready);
    cover property (o_byte_last && i_byte_ready);
endmodule
bind bsmr_readout bsmr_readout_props props_u (.*);
`default_nettype wire

// ---- testbench/bsmr_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module bsmr_master (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    output logic o_ready
);
    logic [7:0] rx_q[$];
    logic [3:0] lf_q = 4'h9;
    initial o_ready = 1'b1;
    // take accepted bytes in order, stall at random when slow
    always @(posedge i_clk) begin
        if (o_ready && i_valid) rx_q.push_back(i_byte);
        lf_q <= {lf_q[2:0], lf_q[3] ^ lf_q[2]};
        #1 o_ready <= !i_slow || lf_q[0];
    end
endmodule
`default_nettype wire

// ---- testbench/breaker_status_modbus_readout_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module breaker_status_modbus_readout_test;
    logic i_clk = 0, i_rstn = 0, req_valid = 0, slow = 0, got_err, busy, bv, bl, err, rdy;
    logic [15:0] r = 16'h9309, req_addr = 0, req_count = 0, ra, rn;
    logic [7:0] bt;
    integer error_cnt = 0, check_count = 0, cyc = 0;
    // ----------------------------------------
    // dataset block plan, then corner counts
    // ----------------------------------------
    logic [15:0] ta[8] = '{16'h7CFF, 16'h7D7B, 16'h7E53, 16'h7D00,
        16'h7CFF, 16'h7CFF, 16'h7D00, 16'h7CFF};
    logic [15:0] tn[8] = '{16'h007C, 16'h0076, 16'h0060, 16'h0001,
        16'h007D, 16'h0000, 16'h007E, 16'h0002};
    bsmr_readout dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_open_closed_contact(r[0]),
        .i_trip_contact(r[1]), .i_fault_trip_contact(r[2]), .i_spring_charged_contact(r[3]),
        .i_motor_operator(r[4]), .i_data_unavail(r[5]), .i_contact_valid(r[9:6]),
        .i_req_valid(req_valid), .i_req_addr(req_addr), .i_req_count(req_count),
        .i_byte_ready(rdy), .o_busy(busy), .o_byte_valid(bv), .o_byte(bt),
        .o_byte_last(bl), .o_req_error(err));
    bsmr_master master_u (.i_clk(i_clk), .i_slow(slow), .i_valid(bv), .i_byte(bt),
        .o_ready(rdy));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected register word from the contact inputs held in v
    function automatic logic [15:0] exp_word(input logic [15:0] adr, input logic [15:0] v);
        if (adr == 16'h7CFF) return {~v[5], 11'h000, v[9:6]};
        if (adr == 16'h7D00) return {v[5], 11'h000, v[3] & ~v[4], v[2], v[1] & ~v[4], v[0]};
        return 16'h0000;
    endfunction
    task complete_run;
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one request, a refused retry while busy, wait for the end
    task automatic rd(input logic [15:0] a, input logic [15:0] n);
        int t;
        master_u.rx_q.delete();
        req_addr = a;
        req_count = n;
        req_valid = 1;
        @(posedge i_clk);
        #1 got_err = err;
        req_valid = 0;
        t = 0;
        while (busy !== 1'b0 && t < 1000) begin
            @(posedge i_clk);
            #1 t++;
            req_valid = (t == 2);
        end
        if (req_valid) req_valid = 0;
        `CHK(busy, 1'b0)
    endtask
    // one read checked against expectations worked out from the rules
    task automatic run_rd(input logic [15:0] a, input logic [15:0] n);
        logic [15:0] a2, e, got;
        logic [3:0] mk;
        rd(a, n);
        `CHK(got_err, n == 0 || n > 125)
        if (got_err === 1'b0) begin
            `CHK(master_u.rx_q.size(), 2 * n + 1)
            `CHK(master_u.rx_q[0], {n[6:0], 1'b0})
            mk = r[5] ? 4'h0 : 4'hF;
            for (int j = 0; j < n; j++) begin
                a2 = a + 16'(j);
                e = exp_word(a2, r);
                got = {master_u.rx_q[2*j+1], master_u.rx_q[2*j+2]};
                if (a2 != 16'h7D00) begin
                    `CHK(got, e)
                end else begin
                    `CHK(got[15], e[15])
                    `CHK(got[3:0] & mk, e[3:0] & mk)
                    `CHK(got[14:4] & {11{~r[5]}}, 11'h000)
                end
            end
        end
    endtask
    initial forever #2 i_clk = ~i_clk;
    // cycle ceiling against hangs
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin error_cnt++; complete_run(); end
    end
    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        #1 i_rstn = 1;
        for (int k = 0; k < 16; k++) begin
            r = lfsr(r);
            slow = r[10];
            if (k < 8) begin
                ra = ta[k];
                rn = tn[k];
            end else begin
                ra = 16'h7CFC + {13'h0000, r[13:11]};
                rn = {9'h000, r[15:9]};
            end
            repeat (2) @(posedge i_clk);
            #1 run_rd(ra, rn);
        end
        // reset in mid response, then a clean read
        repeat (2) @(posedge i_clk);
        #1 req_addr = 16'h7CFF;
        req_count = 16'h007C;
        req_valid = 1;
        @(posedge i_clk);
        #1 req_valid = 0;
        repeat (4) @(posedge i_clk);
        #1 i_rstn = 0;
        @(posedge i_clk);
        #1 `CHK({busy, bv, bl, err}, 4'h0)
        i_rstn = 1;
        repeat (2) @(posedge i_clk);
        #1 run_rd(16'h7D00, 16'h0001);
        complete_run();
    end
endmodule
`default_nettype wire
